/* File: pfd_regs.sv */
// Pin function select and pad drive strength register bank on APB
// Behaviour
// RULE1 - Each pin has 4-bit select, pin n at 4n
// RULE2 - Port E high covers pins 8-12 only
// RULE3 - Port F high covers pins 8-12 only
// RULE4 - Port G high covers pins 8-15, low bits reset zero
// RULE5 - Other select registers reset zero, read/write
// RULE6 - Memory data pad strength at bits 7:6
// RULE7 - Memory address pad strength at bits 5:4
// RULE8 - Memory control pad strength at bits 3:2
// RULE9 - Memory clock pad strength at bits 1:0
// RULE10 - Memory strength resets zero, upper bits reserved
// RULE11 - Port B pins 0-7 get 3-bit strength code
// RULE12 - Port B strength resets to code 100 everywhere
// RULE13 - Reads return written fields, reserved read zero
`timescale 1ns/10ps
module pfd_regs import pfd_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	output      logic [31:0] port_e_high_function_select,
	output      logic [31:0] port_f_low_function_select,
	output      logic [31:0] port_f_high_function_select,
	output      logic [31:0] port_g_low_function_select,
	output      logic [31:0] port_g_high_function_select,
	output      logic [1:0]  mem_data_pad_strength,
	output      logic [1:0]  mem_address_pad_strength,
	output      logic [1:0]  mem_control_pad_strength,
	output      logic [1:0]  mem_clock_pad_strength,
	output      logic [23:0] port_b_pin_strength
);
	pfd_wr_if wr ();

	logic [31:0] regs_q [PFD_NREG];
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [6:0]  hit;
	logic        mapped;
	logic [31:0] rd_mux;
	logic        access;

	// Address decode
	always_comb begin
		hit = 7'h00;
		unique case (paddr)
			PFD_OFS_E_HIGH:   hit[PFD_IDX_E_HIGH]   = 1'b1;
			PFD_OFS_F_LOW:    hit[PFD_IDX_F_LOW]    = 1'b1;
			PFD_OFS_F_HIGH:   hit[PFD_IDX_F_HIGH]   = 1'b1;
			PFD_OFS_G_LOW:    hit[PFD_IDX_G_LOW]    = 1'b1;
			PFD_OFS_G_HIGH:   hit[PFD_IDX_G_HIGH]   = 1'b1;
			PFD_OFS_MEM_DS:   hit[PFD_IDX_MEM_DS]   = 1'b1;
			PFD_OFS_B_LOW_DS: hit[PFD_IDX_B_LOW_DS] = 1'b1;
			default:          hit = 7'h00;
		endcase
	end

	assign mapped = |hit;

	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < PFD_NREG; i++) begin
			if (hit[i]) begin
				rd_mux = regs_q[i]; // [RULE13]
			end
		end
	end

	// One wait state keeps pready and prdata straight from flops
	assign access   = psel & penable;
	assign wr.wdata = pwdata;
	assign wr.wr_en = (access & pready_q & pwrite) ? hit : 7'h00; // [RULE5]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access & ~pready_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (access & ~pready_q) begin
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= ~mapped;
		end else begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Select registers; high halves of E and F keep bits 31:20 reserved
	pfd_reg_cell #(.IDX(PFD_IDX_E_HIGH), .RST_VAL(PFD_RST_ZERO), .MASK(PFD_MASK_HIGH5)) u_e_high ( // [RULE2]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_E_HIGH])
	);
	pfd_reg_cell #(.IDX(PFD_IDX_F_LOW), .RST_VAL(PFD_RST_ZERO), .MASK(PFD_MASK_FULL)) u_f_low ( // [RULE1]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_F_LOW])
	);
	pfd_reg_cell #(.IDX(PFD_IDX_F_HIGH), .RST_VAL(PFD_RST_ZERO), .MASK(PFD_MASK_HIGH5)) u_f_high ( // [RULE3]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_F_HIGH])
	);
	pfd_reg_cell #(.IDX(PFD_IDX_G_LOW), .RST_VAL(PFD_RST_ZERO), .MASK(PFD_MASK_FULL)) u_g_low ( // [RULE5]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_G_LOW])
	);
	// Undefined upper reset bits are pinned to zero for determinism
	pfd_reg_cell #(.IDX(PFD_IDX_G_HIGH), .RST_VAL(PFD_RST_G_HIGH), .MASK(PFD_MASK_FULL)) u_g_high ( // [RULE4]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_G_HIGH])
	);
	// Reserved codes are stored as written; software must pick 01 or 11
	pfd_reg_cell #(.IDX(PFD_IDX_MEM_DS), .RST_VAL(PFD_RST_ZERO), .MASK(PFD_MASK_MEM_DS)) u_mem_ds ( // [RULE10]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_MEM_DS])
	);
	pfd_reg_cell #(.IDX(PFD_IDX_B_LOW_DS), .RST_VAL(PFD_RST_B_LOW_DS), .MASK(PFD_MASK_FULL)) u_b_ds ( // [RULE12]
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr),
		.value_q (regs_q[PFD_IDX_B_LOW_DS])
	);

	// Pad controls come straight from the register flops
	assign port_e_high_function_select = regs_q[PFD_IDX_E_HIGH];
	assign port_f_low_function_select  = regs_q[PFD_IDX_F_LOW];
	assign port_f_high_function_select = regs_q[PFD_IDX_F_HIGH];
	assign port_g_low_function_select  = regs_q[PFD_IDX_G_LOW];
	assign port_g_high_function_select = regs_q[PFD_IDX_G_HIGH];

	assign mem_data_pad_strength    = regs_q[PFD_IDX_MEM_DS][PFD_MEM_DATA_LSB +: PFD_MEM_FIELD_W]; // [RULE6]
	assign mem_address_pad_strength = regs_q[PFD_IDX_MEM_DS][PFD_MEM_ADDR_LSB +: PFD_MEM_FIELD_W]; // [RULE7]
	assign mem_control_pad_strength = regs_q[PFD_IDX_MEM_DS][PFD_MEM_CTRL_LSB +: PFD_MEM_FIELD_W]; // [RULE8]
	assign mem_clock_pad_strength   = regs_q[PFD_IDX_MEM_DS][PFD_MEM_CLK_LSB +: PFD_MEM_FIELD_W]; // [RULE9]

	// Only the low three bits of each 4-bit field drive the pad
	for (genvar p = 0; p < PFD_PINS_PER_REG; p++) begin : g_pb
		assign port_b_pin_strength[p*PFD_PORTB_CODE_W +: PFD_PORTB_CODE_W] =
			regs_q[PFD_IDX_B_LOW_DS][p*PFD_FIELD_W +: PFD_PORTB_CODE_W]; // [RULE11]
	end
endmodule

/* File: pfd_pkg.sv */
// Offsets, reset values and field layout of the pin function and drive registers
package pfd_pkg;
	localparam int          PFD_NREG           = 7;
	localparam int          PFD_ADDR_W         = 12;
	localparam int          PFD_FIELD_W        = 4;
	localparam int          PFD_PINS_PER_REG   = 8;
	localparam int          PFD_MEM_FIELD_W    = 2;
	localparam int          PFD_PORTB_CODE_W   = 3;

	// Register indices
	localparam int          PFD_IDX_E_HIGH     = 0;
	localparam int          PFD_IDX_F_LOW      = 1;
	localparam int          PFD_IDX_F_HIGH     = 2;
	localparam int          PFD_IDX_G_LOW      = 3;
	localparam int          PFD_IDX_G_HIGH     = 4;
	localparam int          PFD_IDX_MEM_DS     = 5;
	localparam int          PFD_IDX_B_LOW_DS   = 6;

	// Byte offsets from the system block base
	localparam logic [11:0] PFD_OFS_E_HIGH     = 12'h094;
	localparam logic [11:0] PFD_OFS_F_LOW      = 12'h098;
	localparam logic [11:0] PFD_OFS_F_HIGH     = 12'h09C;
	localparam logic [11:0] PFD_OFS_G_LOW      = 12'h0A0;
	localparam logic [11:0] PFD_OFS_G_HIGH     = 12'h0A4;
	localparam logic [11:0] PFD_OFS_MEM_DS     = 12'h0F0;
	localparam logic [11:0] PFD_OFS_B_LOW_DS   = 12'h0F4;

	// Reset values
	localparam logic [31:0] PFD_RST_ZERO       = 32'h0000_0000;
	localparam logic [31:0] PFD_RST_G_HIGH     = 32'h0000_0000;
	localparam logic [31:0] PFD_RST_B_LOW_DS   = 32'h4444_4444;

	// Implemented bits; reserved bits hold and read zero
	localparam logic [31:0] PFD_MASK_FULL      = 32'hFFFF_FFFF;
	localparam logic [31:0] PFD_MASK_HIGH5     = 32'h000F_FFFF;
	localparam logic [31:0] PFD_MASK_MEM_DS    = 32'h0000_00FF;

	// Memory pad strength fields
	localparam int          PFD_MEM_DATA_LSB   = 6;
	localparam int          PFD_MEM_ADDR_LSB   = 4;
	localparam int          PFD_MEM_CTRL_LSB   = 2;
	localparam int          PFD_MEM_CLK_LSB    = 0;
	localparam logic [1:0]  PFD_MEM_REDUCED    = 2'h1;
	localparam logic [1:0]  PFD_MEM_FULL       = 2'h3;
endpackage

/* File: pfd_wr_if.sv */
// Write path from the bus slave to the register cells
`timescale 1ns/10ps
interface pfd_wr_if;
	logic [31:0] wdata;
	logic [6:0]  wr_en;

	modport src (output wdata, output wr_en);
	modport dst (input wdata, input wr_en);
endinterface

/* File: pfd_reg_cell.sv */
// One software register with reset value and implemented-bit mask
`timescale 1ns/10ps
module pfd_reg_cell import pfd_pkg::*; #(
	parameter int          IDX      = 0,
	parameter logic [31:0] RST_VAL  = 32'h0000_0000,
	parameter logic [31:0] MASK     = 32'hFFFF_FFFF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	pfd_wr_if.dst            wr,
	output      logic [31:0] value_q
);
	// Reserved bits never store, so reads give zero there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= RST_VAL & MASK;
		end else if (wr.wr_en[IDX]) begin
			value_q <= wr.wdata & MASK; // [RULE13]
		end
	end
endmodule

/* File: pfd_props.sv */
// Checker for the pin function and drive register bank
`timescale 1ns/10ps
module pfd_props import pfd_pkg::*; (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] port_e_high_function_select,
	input wire logic [31:0] port_f_low_function_select,
	input wire logic [31:0] port_f_high_function_select,
	input wire logic [31:0] port_g_low_function_select,
	input wire logic [31:0] port_g_high_function_select,
	input wire logic [1:0]  mem_data_pad_strength,
	input wire logic [1:0]  mem_address_pad_strength,
	input wire logic [1:0]  mem_control_pad_strength,
	input wire logic [1:0]  mem_clock_pad_strength,
	input wire logic [23:0] port_b_pin_strength
);
	logic acc;
	assign acc = psel & penable & pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wr_mem; acc && pwrite && paddr == PFD_OFS_MEM_DS; endsequence
	sequence s_wr_b; acc && pwrite && paddr == PFD_OFS_B_LOW_DS; endsequence
	property p_e_rsv; port_e_high_function_select[31:20] == 12'h000; endproperty
	a_e_rsv: assert property (p_e_rsv) else $error("port e reserved bits set");
	property p_f_rsv; port_f_high_function_select[31:20] == 12'h000; endproperty
	a_f_rsv: assert property (p_f_rsv) else $error("port f reserved bits set");
	property p_g_low; acc && pwrite && paddr == PFD_OFS_G_LOW |=> port_g_low_function_select == $past(pwdata); endproperty
	a_g_low: assert property (p_g_low) else $error("port g low not written");
	property p_mem_hi; s_wr_mem |=> {mem_data_pad_strength, mem_address_pad_strength} == $past(pwdata[7:4]); endproperty
	a_mem_hi: assert property (p_mem_hi) else $error("memory data or address strength wrong");
	property p_mem_lo; s_wr_mem |=> {mem_control_pad_strength, mem_clock_pad_strength} == $past(pwdata[3:0]); endproperty
	a_mem_lo: assert property (p_mem_lo) else $error("memory control or clock strength wrong");
	property p_mem_rd; acc && !pwrite && paddr == PFD_OFS_MEM_DS |-> prdata[31:8] == 24'h000000; endproperty
	a_mem_rd: assert property (p_mem_rd) else $error("memory strength reserved bits read set");
	property p_b_pad; s_wr_b |=> {port_b_pin_strength[23:21], port_b_pin_strength[2:0]} == {$past(pwdata[30:28]), $past(pwdata[2:0])}; endproperty
	a_b_pad: assert property (p_b_pad) else $error("port b pad code wrong");
	property p_b_rst; $rose(presetn) |-> port_b_pin_strength == 24'h924924; endproperty
	a_b_rst: assert property (p_b_rst) else $error("port b strength reset wrong");
	// One wait state, so no transfer stalls longer than a cycle
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("access not answered");
endmodule
bind pfd_regs pfd_props u_props (.*);

/* File: test_pin_function_and_drive_regs.sv */
// Testbench for the pin function and drive register bank
`timescale 1ns/10ps
module test_pin_function_and_drive_regs import pfd_pkg::*;;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [31:0] port_e_high_function_select, port_f_low_function_select, port_f_high_function_select;
	logic [31:0] port_g_low_function_select, port_g_high_function_select;
	logic [1:0]  mem_data_pad_strength, mem_address_pad_strength, mem_control_pad_strength, mem_clock_pad_strength;
	logic [23:0] port_b_pin_strength;
	int          num_errors = 0, checks = 0;
	logic [11:0] ofs [7] = '{PFD_OFS_E_HIGH, PFD_OFS_F_LOW, PFD_OFS_F_HIGH, PFD_OFS_G_LOW, PFD_OFS_G_HIGH,
		PFD_OFS_MEM_DS, PFD_OFS_B_LOW_DS};
	logic [31:0] msk [7] = '{32'h000F_FFFF, 32'hFFFF_FFFF, 32'h000F_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
		32'h0000_00FF, 32'hFFFF_FFFF};
	always #2.5 pclk = ~pclk;
	pfd_regs dut_u (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until pready; penable dropped here so back to back needs no extra edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// No local limit; a hung slave is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		xfer(1'h0, a, 32'h0);
		chk(r & m, x);
	endtask
	task automatic fin(input string s);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		$display("%s done", s);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_reset;
		chk({8'h00, port_b_pin_strength}, 32'h0092_4924);
		for (int i = 0; i < 7; i++) rd(ofs[i], (i == 4) ? 32'h0000_0FFF : 32'hFFFF_FFFF, (i == 6) ? 32'h4444_4444 : 32'h0);
		chk({31'h0, e}, 32'h0);
		fin("reset");
	endtask
	task automatic t_rw;
		logic [31:0] p [2] = '{32'hFFFF_FFFF, 32'hFEDC_BA98};
		for (int j = 0; j < 2; j++) for (int i = 0; i < 7; i++) begin
			xfer(1'h1, ofs[i], p[j]);
			rd(ofs[i], 32'hFFFF_FFFF, p[j] & msk[i]);
		end
		chk(port_e_high_function_select, 32'h000C_BA98);
		chk(port_f_low_function_select, 32'hFEDC_BA98);
		chk(port_f_high_function_select, 32'h000C_BA98);
		chk(port_g_low_function_select, 32'hFEDC_BA98);
		chk(port_g_high_function_select, 32'hFEDC_BA98);
		chk({8'h00, port_b_pin_strength}, 32'h00FA_C688);
		fin("read write");
	endtask
	task automatic t_mem;
		logic [1:0] c;
		logic [7:0] b;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			b = {c, c + 2'h1, c + 2'h2, c + 2'h3};
			xfer(1'h1, PFD_OFS_MEM_DS, {24'hFF_FFFF, b});
			rd(PFD_OFS_MEM_DS, 32'hFFFF_FFFF, {24'h0, b});
			chk({24'h0, mem_data_pad_strength, mem_address_pad_strength, mem_control_pad_strength, mem_clock_pad_strength}, {24'h0, b});
		end
		fin("memory strength");
	endtask
	task automatic t_portb;
		xfer(1'h1, PFD_OFS_B_LOW_DS, 32'h0123_4567);
		rd(PFD_OFS_B_LOW_DS, 32'hFFFF_FFFF, 32'h0123_4567);
		chk({8'h00, port_b_pin_strength}, 32'h0005_3977);
		xfer(1'h1, 12'h0F8, 32'hFFFF_FFFF);
		chk({31'h0, e}, 32'h1);
		chk({8'h00, port_b_pin_strength}, 32'h0005_3977);
		rd(12'h0F8, 32'hFFFF_FFFF, 32'h0);
		chk({31'h0, e}, 32'h1);
		fin("port b and unmapped");
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_rw;
		t_mem;
		t_portb;
		report_and_stop;
	end
	// Whole run needs about 160 cycles
	initial begin
		#20000;
		num_errors++;
		report_and_stop;
	end
endmodule
